// >>> afm_pkg.sv
/*
 * Shared constants and carrier types of the accumulator and fault flag bank.
 * Assumes a host-side serial front end that turns bus traffic into register
 * read and write strobes with a register index.
 */
package afm_pkg;

    localparam logic [7:0]  ADDR_ENERGY      = 8'h09;
    localparam logic [7:0]  ADDR_CHARGE      = 8'h0a;
    localparam logic [7:0]  ADDR_DIAG        = 8'h0b;

    localparam int          ACC_W            = 40;
    localparam int          REG_W            = 16;

    localparam int          BIT_HOLD_SEL     = 15;
    localparam int          BIT_DONE_ALERT   = 14;
    localparam int          BIT_AVG_CMP      = 13;
    localparam int          BIT_SENSE        = 12;
    localparam int          BIT_JOULE_OF     = 11;
    localparam int          BIT_COUL_OF      = 10;
    localparam int          BIT_MATH_OF      = 9;
    localparam int          BIT_RSVD         = 8;
    localparam int          BIT_OVERTEMP     = 7;
    localparam int          BIT_OVERCUR      = 6;
    localparam int          BIT_UNDERCUR     = 5;
    localparam int          BIT_BUS_OV       = 4;
    localparam int          BIT_BUS_UV       = 3;
    localparam int          BIT_PWR_OL       = 2;
    localparam int          BIT_DONE         = 1;
    localparam int          BIT_TRIM_OK      = 0;

    localparam logic [15:0] DIAG_RESET       = 16'h0001;
    localparam logic [15:0] DIAG_WR_MASK     = 16'hf000;
    localparam logic [39:0] ACC_RESET        = 40'h00_0000_0000;
    localparam logic [2:0]  AVG_SINGLE       = 3'h0;

    // Limit violations seen by the comparators, one bit per flag
    typedef struct packed {
        logic overtemp;
        logic overcur;
        logic undercur;
        logic bus_ov;
        logic bus_uv;
        logic pwr_ol;
    } afm_limits_t;

    // Register access strobe from the serial front end
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [15:0] wdata;
    } afm_req_t;

endpackage : afm_pkg

// >>> afm_snapshot.sv
/*
 * Read snapshot: captures a whole register at the first byte of a read and
 * shifts it out most significant byte first.
 * Assumes the front end pulses load at the start of each register read and
 * next for every further byte.
 */
module afm_snapshot
    import afm_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    input  wire logic              load_i,
    input  wire logic [ACC_W-1:0]  value_i,
    input  wire logic [2:0]        nbytes_i,
    input  wire logic              next_i,
    output logic      [7:0]        byte_o
);
    import afm_pkg::*;

    logic [ACC_W-1:0] shadow_ff;

    // Value left aligned so the top byte is always the first sent
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            shadow_ff <= ACC_RESET;
        end else if (load_i) begin
            shadow_ff <= (nbytes_i == 3'd5) ? value_i : {value_i[REG_W-1:0], 24'h00_0000};
        end else if (next_i) begin
            shadow_ff <= {shadow_ff[ACC_W-9:0], 8'h00};
        end
    end

    assign byte_o = shadow_ff[ACC_W-1:ACC_W-8];

    snap_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !load_i && !next_i |=> $stable(shadow_ff))
        else $error("snapshot changed mid read");

endmodule : afm_snapshot

// >>> afm_bank.sv
/*
 * Accumulator and fault flag register bank of the power monitor.
 * Assumes the serial front end delivers one request strobe per register
 * access and per-byte read pulses, and that the datapath supplies sample,
 * average and accumulate events already synchronous to sys_clk_i.
 */
// What this block does
// - Read-only unsigned 40-bit energy accumulator
// - Read-only signed 40-bit charge accumulator
// - Bit 15 chooses transparent or latched alert
// - Bit 14 routes conversion done to alert
// - Bit 13 compares averaged instead of raw
// - Bit 12 sets alert pin active sense
// - Energy overflow flag, cleared by accumulator clear
// - Charge overflow flag, cleared by accumulator clear
// - Math overflow, cleared by conversion or clear
// - Bit 8 reserved, reads zero
// - Overtemperature flag, read clears when latched
// - Overcurrent flag, read clears when latched
// - Undercurrent flag, read clears when latched
// - Bus overvoltage flag, read clears when latched
// - Bus undervoltage flag, read clears when latched
// - Power over limit flag, read clears latched
// - Done flag, cleared by trigger, or by read when latched
// - Trim checksum status resets one, error zero
// - Averaged results update only after sequence
module afm_bank
    import afm_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    input  afm_pkg::afm_req_t      req_i,
    input  wire logic              rd_next_i,
    output logic      [7:0]        rd_byte_o,
    output logic      [2:0]        rd_len_o,
    input  wire logic [2:0]        averaging_count_i,
    input  wire logic              sample_i,
    input  wire logic              avg_done_i,
    input  afm_pkg::afm_limits_t   raw_limits_i,
    input  afm_pkg::afm_limits_t   avg_limits_i,
    input  wire logic              conv_start_i,
    input  wire logic              accumulator_clear_i,
    input  wire logic              acc_step_i,
    input  wire logic [31:0]       energy_inc_i,
    input  wire logic [31:0]       charge_inc_i,
    input  wire logic              math_of_i,
    input  wire logic              trim_err_i,
    output logic                   result_update_o,
    output logic                   alert_o,
    output logic                   alert_oe_n_o
);
    import afm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Accumulators

    logic [ACC_W-1:0] energy_ff;
    logic [ACC_W-1:0] charge_ff;
    logic [ACC_W:0]   nxt_energy;
    logic [ACC_W-1:0] nxt_charge;
    logic             charge_of;
    logic [ACC_W-1:0] charge_ext;

    assign nxt_energy = {1'b0, energy_ff} + {9'h000, energy_inc_i};
    assign charge_ext = {{8{charge_inc_i[31]}}, charge_inc_i};
    assign nxt_charge = charge_ff + charge_ext;
    // Signed overflow: both operands alike in sign, sum differs
    assign charge_of  = (charge_ff[ACC_W-1] == charge_ext[ACC_W-1])
                     && (nxt_charge[ACC_W-1] != charge_ff[ACC_W-1]);

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            energy_ff <= ACC_RESET;
            charge_ff <= ACC_RESET;
        end else if (accumulator_clear_i) begin
            energy_ff <= ACC_RESET;
            charge_ff <= ACC_RESET;
        end else if (acc_step_i) begin
            energy_ff <= nxt_energy[ACC_W-1:0];
            charge_ff <= nxt_charge;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control bits

    logic hold_sel_ff;
    logic done_alert_ff;
    logic avg_cmp_ff;
    logic sense_ff;
    logic diag_wr;
    logic diag_rd;

    assign diag_wr = req_i.wr && (req_i.addr == ADDR_DIAG);
    assign diag_rd = req_i.rd && (req_i.addr == ADDR_DIAG);

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hold_sel_ff   <= DIAG_RESET[BIT_HOLD_SEL];
            done_alert_ff <= DIAG_RESET[BIT_DONE_ALERT];
            avg_cmp_ff    <= DIAG_RESET[BIT_AVG_CMP];
            sense_ff      <= DIAG_RESET[BIT_SENSE];
        end else if (diag_wr) begin
            hold_sel_ff   <= req_i.wdata[BIT_HOLD_SEL];
            done_alert_ff <= req_i.wdata[BIT_DONE_ALERT];
            avg_cmp_ff    <= req_i.wdata[BIT_AVG_CMP];
            sense_ff      <= req_i.wdata[BIT_SENSE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result update timing

    logic result_update_ff;
    logic result_event;

    // Averaging above one sample publishes only at the end of the sequence
    assign result_event = (averaging_count_i == AVG_SINGLE) ? sample_i : avg_done_i;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            result_update_ff <= 1'b0;
        end else begin
            result_update_ff <= result_event;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overflow flags

    logic joule_of_ff;
    logic coulomb_of_ff;
    logic math_of_ff;

    // Clear wins over set so an overflow during a clear is dropped
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            joule_of_ff   <= 1'b0;
            coulomb_of_ff <= 1'b0;
        end else begin
            if (acc_step_i && !accumulator_clear_i && nxt_energy[ACC_W]) begin
                joule_of_ff <= 1'b1;
            end else if (accumulator_clear_i) begin
                joule_of_ff <= 1'b0;
            end
            if (acc_step_i && !accumulator_clear_i && charge_of) begin
                coulomb_of_ff <= 1'b1;
            end else if (accumulator_clear_i) begin
                coulomb_of_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            math_of_ff <= 1'b0;
        end else if (math_of_i) begin
            math_of_ff <= 1'b1;
        end else if (conv_start_i || accumulator_clear_i) begin
            math_of_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Limit and conversion flags

    afm_limits_t limits_ff;
    afm_limits_t cmp_src;
    logic        cmp_valid;
    logic        done_ff;
    logic        trim_ok_ff;

    // Raw mode checks every sample, averaged mode only finished averages
    assign cmp_src   = avg_cmp_ff ? avg_limits_i : raw_limits_i;
    assign cmp_valid = avg_cmp_ff ? avg_done_i : sample_i;

    function automatic logic flag_next(input logic cur, input logic hit, input logic valid,
                                       input logic latched, input logic rd_clr);
        logic r;
        r = cur;
        if (latched) begin
            if (valid && hit) begin
                r = 1'b1;
            end else if (rd_clr) begin
                r = 1'b0;
            end
        end else if (valid) begin
            r = hit;
        end
        return r;
    endfunction : flag_next

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            limits_ff <= '0;
        end else begin
            limits_ff.overtemp <= flag_next(limits_ff.overtemp, cmp_src.overtemp, cmp_valid,
                                            hold_sel_ff, diag_rd);
            limits_ff.overcur  <= flag_next(limits_ff.overcur, cmp_src.overcur, cmp_valid,
                                            hold_sel_ff, diag_rd);
            limits_ff.undercur <= flag_next(limits_ff.undercur, cmp_src.undercur, cmp_valid,
                                            hold_sel_ff, diag_rd);
            limits_ff.bus_ov   <= flag_next(limits_ff.bus_ov, cmp_src.bus_ov, cmp_valid,
                                            hold_sel_ff, diag_rd);
            limits_ff.bus_uv   <= flag_next(limits_ff.bus_uv, cmp_src.bus_uv, cmp_valid,
                                            hold_sel_ff, diag_rd);
            limits_ff.pwr_ol   <= flag_next(limits_ff.pwr_ol, cmp_src.pwr_ol, cmp_valid,
                                            hold_sel_ff, diag_rd);
        end
    end

    // Done sets on each published result; a trigger clears it in either mode
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            done_ff <= 1'b0;
        end else if (result_event) begin
            done_ff <= 1'b1;
        end else if (conv_start_i || (hold_sel_ff && diag_rd)) begin
            done_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            trim_ok_ff <= DIAG_RESET[BIT_TRIM_OK];
        end else if (trim_err_i) begin
            trim_ok_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Alert pin

    logic alert_act;
    logic alert_ff;
    logic alert_oe_n_ff;

    assign alert_act = (|limits_ff) || (done_alert_ff && done_ff);

    // Open drain: pull low for an active alert with active-low sense or an idle one with active-high sense, else release
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            alert_ff      <= 1'b0;
            alert_oe_n_ff <= 1'b1;
        end else begin
            alert_ff      <= 1'b0;
            alert_oe_n_ff <= ~(alert_act ^ sense_ff);
        end
    end

    assign alert_o         = alert_ff;
    assign alert_oe_n_o    = alert_oe_n_ff;
    assign result_update_o = result_update_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    logic [REG_W-1:0] diag_value;
    logic [ACC_W-1:0] rd_value;
    logic [2:0]       rd_len;
    logic [2:0]       rd_len_ff;

    always_comb begin
        diag_value                 = '0;
        diag_value[BIT_HOLD_SEL]   = hold_sel_ff;
        diag_value[BIT_DONE_ALERT] = done_alert_ff;
        diag_value[BIT_AVG_CMP]    = avg_cmp_ff;
        diag_value[BIT_SENSE]      = sense_ff;
        diag_value[BIT_JOULE_OF]   = joule_of_ff;
        diag_value[BIT_COUL_OF]    = coulomb_of_ff;
        diag_value[BIT_MATH_OF]    = math_of_ff;
        diag_value[BIT_OVERTEMP]   = limits_ff.overtemp;
        diag_value[BIT_OVERCUR]    = limits_ff.overcur;
        diag_value[BIT_UNDERCUR]   = limits_ff.undercur;
        diag_value[BIT_BUS_OV]     = limits_ff.bus_ov;
        diag_value[BIT_BUS_UV]     = limits_ff.bus_uv;
        diag_value[BIT_PWR_OL]     = limits_ff.pwr_ol;
        diag_value[BIT_DONE]       = done_ff;
        diag_value[BIT_TRIM_OK]    = trim_ok_ff;
    end

    always_comb begin
        rd_value = ACC_RESET;
        rd_len   = 3'd2;
        case (req_i.addr)
            ADDR_ENERGY: begin
                rd_value = energy_ff;
                rd_len   = 3'd5;
            end
            ADDR_CHARGE: begin
                rd_value = charge_ff;
                rd_len   = 3'd5;
            end
            ADDR_DIAG: begin
                rd_value = {24'h00_0000, diag_value};
            end
            default: begin
                rd_value = ACC_RESET;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_len_ff <= 3'd2;
        end else if (req_i.rd) begin
            rd_len_ff <= rd_len;
        end
    end

    assign rd_len_o = rd_len_ff;

    afm_snapshot u_snapshot (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .load_i    (req_i.rd),
        .value_i   (rd_value),
        .nbytes_i  (rd_len),
        .next_i    (rd_next_i),
        .byte_o    (rd_byte_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    clear_accum_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        accumulator_clear_i |=> energy_ff == ACC_RESET && charge_ff == ACC_RESET)
        else $error("accumulators not cleared");
    joule_sticky_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        joule_of_ff && !accumulator_clear_i |=> joule_of_ff)
        else $error("energy overflow lost");
    coul_clear_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        accumulator_clear_i |=> !coulomb_of_ff)
        else $error("charge overflow not cleared");
    math_clear_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        conv_start_i && !math_of_i |=> !math_of_ff)
        else $error("math overflow not cleared");
    rsvd_zero_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        diag_value[BIT_RSVD] == 1'b0)
        else $error("reserved bit set");
    latch_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        hold_sel_ff && limits_ff.overcur && !diag_rd && !diag_wr |=> limits_ff.overcur)
        else $error("latched flag dropped");
    latch_rdclr_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        hold_sel_ff && diag_rd && !cmp_valid && !diag_wr |=> limits_ff == '0)
        else $error("read did not clear flags");
    done_alert_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        done_alert_ff && done_ff && !diag_wr |=> alert_oe_n_ff == sense_ff)
        else $error("done not on alert");
    trim_sticky_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        trim_err_i |=> !trim_ok_ff ##1 !trim_ok_ff)
        else $error("trim status recovered");
    avg_update_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        averaging_count_i != AVG_SINGLE && !avg_done_i |=> !result_update_ff)
        else $error("early result update");

endmodule : afm_bank

// >>> afm_host.sv
/*
 * Host controller model on the management side of the bank: issues register
 * writes and multi-byte register reads through the request strobe.
 * Assumes the bank takes one strobe per access, answers the first byte one
 * cycle later and one further byte per advance pulse.
 */
module afm_host
    import afm_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic [7:0]        rd_byte_i,
    output afm_pkg::afm_req_t      req_o,
    output logic                   rd_next_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        req_o     = '0;
        rd_next_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write one register; the strobe stands for a single cycle
    task automatic wr_reg(input logic [7:0] addr, input logic [15:0] data);
        @(posedge sys_clk_i);
        req_o <= '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
        @(posedge sys_clk_i);
        req_o.wr <= 1'b0;
    endtask : wr_reg

    // Read nbytes into the low end of data, first byte is the most significant
    task automatic rd_reg(input logic [7:0] addr, input int nbytes, output logic [39:0] data);
        data = '0;
        @(posedge sys_clk_i);
        req_o <= '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 16'h0000};
        @(posedge sys_clk_i);
        req_o.rd <= 1'b0;
        for (int i = 0; i < nbytes; i++) begin
            @(negedge sys_clk_i);
            data = {data[31:0], rd_byte_i};
            if (i < nbytes - 1) begin
                @(posedge sys_clk_i);
                rd_next_o <= 1'b1;
                @(posedge sys_clk_i);
                rd_next_o <= 1'b0;
            end
        end
    endtask : rd_reg
endmodule : afm_host

// >>> afm_bank_test.sv
/*
 * Self-checking bench of the accumulator and fault flag bank.
 * Assumes the bank's package and the host model; the alert pin has a pull-up.
 */
module afm_bank_test;
    import afm_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [5:0] EV_SMP  = 6'b10_0000;
    localparam logic [5:0] EV_AVG  = 6'b01_0000;
    localparam logic [5:0] EV_CS   = 6'b00_1000;
    localparam logic [5:0] EV_MATH = 6'b00_0100;
    localparam logic [5:0] EV_CLR  = 6'b00_0010;
    localparam logic [5:0] EV_TRIM = 6'b00_0001;

    logic        sys_clk_i;
    logic        rst_i;
    afm_req_t    req;
    logic        rd_next;
    logic [7:0]  rd_byte;
    logic [2:0]  rd_len;
    logic [2:0]  avg_cnt;
    logic [5:0]  evs;
    afm_limits_t raw_lim;
    afm_limits_t avg_lim;
    logic        acc_step;
    logic [31:0] e_inc;
    logic [31:0] c_inc;
    logic        upd;
    logic        alert;
    logic        alert_oe_n;
    wire         alert_pin;
    int          fails = 0;
    int          total_checks = 0;
    int          upd_cnt = 0;
    int          u;
    logic [39:0] v;

    assign alert_pin = alert_oe_n ? 1'b1 : alert;

    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    afm_bank dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req), .rd_next_i(rd_next), .rd_byte_o(rd_byte),
        .rd_len_o(rd_len), .averaging_count_i(avg_cnt), .sample_i(evs[5]), .avg_done_i(evs[4]),
        .raw_limits_i(raw_lim), .avg_limits_i(avg_lim), .conv_start_i(evs[3]), .accumulator_clear_i(evs[1]),
        .acc_step_i(acc_step), .energy_inc_i(e_inc), .charge_inc_i(c_inc), .math_of_i(evs[2]),
        .trim_err_i(evs[0]), .result_update_o(upd), .alert_o(alert), .alert_oe_n_o(alert_oe_n));

    afm_host host (.sys_clk_i(sys_clk_i), .rd_byte_i(rd_byte), .req_o(req), .rd_next_o(rd_next));

    always @(posedge sys_clk_i) begin
        if (upd === 1'b1) begin
            upd_cnt <= upd_cnt + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (fails == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic diag(input logic [15:0] exp);
        host.rd_reg(ADDR_DIAG, 2, v);
        chk("diag", v, {24'h00_0000, exp});
    endtask : diag

    task automatic acc_rd(input logic [7:0] addr, input logic [39:0] exp);
        host.rd_reg(addr, 5, v);
        chk("accumulator", v, exp);
    endtask : acc_rd

    task automatic pin(input logic exp);
        repeat (2) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        chk("alert pin", 40'(alert_pin), 40'(exp));
    endtask : pin

    // One-cycle event pulse together with new comparator levels
    task automatic ev(input logic [5:0] e, input afm_limits_t r, input afm_limits_t a);
        @(posedge sys_clk_i);
        evs     <= e;
        raw_lim <= r;
        avg_lim <= a;
        @(posedge sys_clk_i);
        evs <= '0;
    endtask : ev

    task automatic acc(input logic [31:0] e, input logic [31:0] c, input int n);
        @(posedge sys_clk_i);
        e_inc    <= e;
        c_inc    <= c;
        acc_step <= 1'b1;
        repeat (n) @(posedge sys_clk_i);
        acc_step <= 1'b0;
    endtask : acc

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #50000ns;
        fails++;
        complete_run();
    end

    initial begin
        rst_i    = 1'b1;
        avg_cnt  = 3'h1;
        evs      = '0;
        raw_lim  = '0;
        avg_lim  = '0;
        acc_step = 1'b0;
        e_inc    = '0;
        c_inc    = '0;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        pin(1'b1);
        chk("read length", 40'(rd_len), 40'h2);
        diag(DIAG_RESET);
        acc_rd(ADDR_ENERGY, ACC_RESET);
        chk("read length", 40'(rd_len), 40'h5);
        acc_rd(ADDR_CHARGE, ACC_RESET);
        host.wr_reg(ADDR_DIAG, 16'hffff);
        diag(16'hf001);
        pin(1'b0);
        host.wr_reg(ADDR_ENERGY, 16'hffff);
        acc_rd(ADDR_ENERGY, ACC_RESET);
        host.rd_reg(8'h0c, 2, v);
        chk("unmapped", v, 40'h00_0000_0000);
        host.wr_reg(ADDR_DIAG, 16'h0000);
        // Accumulation, and a step landing in the middle of a read
        acc(32'hffff_ffff, 32'hffff_fffb, 3);
        fork
            acc_rd(ADDR_ENERGY, 40'h02_ffff_fffd);
            begin
                repeat (3) @(posedge sys_clk_i);
                acc(32'h0000_0001, 32'h0000_0002, 1);
            end
        join
        acc_rd(ADDR_ENERGY, 40'h02_ffff_fffe);
        acc_rd(ADDR_CHARGE, 40'hff_ffff_fff3);
        // Overflow boundaries of both accumulators
        ev(EV_CLR, '0, '0);
        acc(32'hffff_ffff, 32'h8000_0000, 256);
        diag(16'h0001);
        acc_rd(ADDR_ENERGY, 40'hff_ffff_ff00);
        acc_rd(ADDR_CHARGE, 40'h80_0000_0000);
        acc(32'hffff_ffff, 32'h8000_0000, 1);
        diag(16'h0c01);
        ev(EV_MATH, '0, '0);
        diag(16'h0e01);
        ev(EV_CS, '0, '0);
        diag(16'h0c01);
        ev(EV_MATH, '0, '0);
        ev(EV_CLR, '0, '0);
        diag(16'h0001);
        acc_rd(ADDR_ENERGY, ACC_RESET);
        // Each limit flag in transparent mode on raw samples
        for (int i = 0; i < 6; i++) begin
            ev(EV_SMP, afm_limits_t'(6'b00_0001 << i), '0);
            pin(1'b0);
            diag(16'h0001 | (16'h0004 << i));
            ev(EV_SMP, '0, '0);
            pin(1'b1);
            diag(16'h0001);
        end
        // Latched mode holds flag and pin until the register is read
        host.wr_reg(ADDR_DIAG, 16'h8000);
        ev(EV_SMP, afm_limits_t'(6'b01_0000), '0);
        ev(EV_SMP, '0, '0);
        pin(1'b0);
        diag(16'h8041);
        pin(1'b1);
        diag(16'h8001);
        // Inverted pin sense with an active flag
        host.wr_reg(ADDR_DIAG, 16'h1000);
        ev(EV_SMP, afm_limits_t'(6'b00_0010), '0);
        pin(1'b1);
        ev(EV_SMP, '0, '0);
        pin(1'b0);
        // Comparison on averaged results only, publishing after the sequence
        host.wr_reg(ADDR_DIAG, 16'h2000);
        u = upd_cnt;
        ev(EV_SMP, afm_limits_t'(6'b10_0000), '0);
        diag(16'h2001);
        chk("update pulses", 40'(upd_cnt - u), 40'h0);
        ev(EV_AVG, '0, afm_limits_t'(6'b10_0000));
        diag(16'h2083);
        chk("update pulses", 40'(upd_cnt - u), 40'h1);
        ev(EV_CS, '0, afm_limits_t'(6'b10_0000));
        diag(16'h2081);
        ev(EV_AVG, '0, '0);
        ev(EV_CS, '0, '0);
        diag(16'h2001);
        // Conversion done routed to the pin, or not
        host.wr_reg(ADDR_DIAG, 16'h4000);
        ev(EV_AVG, '0, '0);
        pin(1'b0);
        ev(EV_CS, '0, '0);
        pin(1'b1);
        host.wr_reg(ADDR_DIAG, 16'h0000);
        ev(EV_AVG, '0, '0);
        pin(1'b1);
        ev(EV_CS, '0, '0);
        host.wr_reg(ADDR_DIAG, 16'h8000);
        ev(EV_AVG, '0, '0);
        diag(16'h8003);
        diag(16'h8001);
        // Latched done flag also cleared by a new triggered conversion
        ev(EV_AVG, '0, '0);
        ev(EV_CS, '0, '0);
        diag(16'h8001);
        ev(EV_TRIM, '0, '0);
        diag(16'h8000);
        @(posedge sys_clk_i);
        avg_cnt <= AVG_SINGLE;
        u = upd_cnt;
        ev(EV_SMP, '0, '0);
        repeat (2) @(posedge sys_clk_i);
        chk("update pulses", 40'(upd_cnt - u), 40'h1);
        complete_run();
    end
endmodule : afm_bank_test
